// ==== pkg/stc_map.vh ====
// Constants shared by the service and test command unit
`ifndef STC_MAP_VH
`define STC_MAP_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define STC_CLK_KHZ 25000
`define STC_REFRESH_MS 250
`define STC_SESSION_S 60
`define STC_LOCK_S 60
// ----------------------------------------
// Sizes and limits
// ----------------------------------------
`define STC_DIST_W 24
`define STC_DIST_MAX 24'h98967F
`define STC_NUM_BAR 8
`define STC_NUM_SLOT 5
`define STC_SLOT_MAX 3'h4
`define STC_LOG_DEPTH 124
`define STC_LOG_W 40
`define STC_PW_MAX 4'h8
`define STC_FAIL_LIMIT 2'h2
// ----------------------------------------
// Reset and factory values
// ----------------------------------------
`define STC_FACT_DIST 24'h000000
`define STC_FACT_LBC_ON 1'b0
`define STC_PW_DEF0 8'h57
`define STC_PW_DEF1 8'h45
`define STC_PW_DEF2 8'h47
`define STC_PW_DEF3 8'h41
`define STC_PW_DEF_LEN 4'h4
// ----------------------------------------
// Character codes
// ----------------------------------------
`define STC_CH_ESC 8'h1B
`define STC_CH_CR 8'h0D
`define STC_CH_STAR 8'h2A
`endif

// ==== src/stc_sync3.v ====
// Three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/10ps
module stc_sync3 #(
  parameter W = 4
) (
  input wire clk,
  input wire rst_b,
  input wire ce,
  input wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);
  genvar b;
  generate
    for (b = 0; b < W; b = b + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg q_reg;
      always @(posedge clk) begin
        if (!rst_b) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          q_reg <= 1'b0;
        end else if (ce) begin
          s1_reg <= d_in[b];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            q_reg <= s3_reg;
          end
        end
      end
      assign q_out[b] = q_reg;
    end
  endgenerate
endmodule

// ==== src/stc_err_log.v ====
// Persistent circular error log with read by age
`timescale 1ns/10ps
`include "stc_map.vh"
module stc_err_log (
  input wire clk,
  input wire ce,
  input wire init,
  input wire wr_en,
  input wire [`STC_LOG_W-1:0] wr_data,
  input wire rd_en,
  input wire [6:0] rd_idx,
  output reg [`STC_LOG_W-1:0] rd_data,
  output reg rd_valid,
  output wire [6:0] count
);
  // Storage survives rst_b; only a blank-store boot empties it
  reg [`STC_LOG_W-1:0] mem [0:`STC_LOG_DEPTH-1];
  reg [6:0] wp_reg;
  reg [6:0] cnt_reg;
  wire [7:0] oldest = (cnt_reg == 7'd124) ? {1'b0, wp_reg} : 8'h00;
  wire [7:0] raw = oldest + {1'b0, rd_idx};
  wire [7:0] addr = (raw >= 8'd124) ? raw - 8'd124 : raw;
  assign count = cnt_reg;
  always @(posedge clk) begin
    if (ce) begin
      rd_valid <= 1'b0;
      if (init) begin
        wp_reg <= 7'h00;
        cnt_reg <= 7'h00;
      end else if (wr_en) begin
        mem[wp_reg] <= wr_data;
        wp_reg <= (wp_reg == 7'd123) ? 7'h00 : wp_reg + 7'h01;
        if (cnt_reg != 7'd124) begin
          cnt_reg <= cnt_reg + 7'h01;
        end
      end
      if (rd_en) begin
        rd_data <= (rd_idx < cnt_reg) ? mem[addr[6:0]] : {`STC_LOG_W{1'b0}};
        rd_valid <= 1'b1;
      end
    end
  end
endmodule

// ==== src/stc_unit.v ====
// Service, test and parameter-store command unit
`timescale 1ns/10ps
`include "stc_map.vh"
module stc_unit #(
  parameter integer REFRESH_CYC = `STC_REFRESH_MS * `STC_CLK_KHZ,
  parameter integer SESSION_CYC = `STC_SESSION_S * 1000 * `STC_CLK_KHZ,
  parameter integer LOCK_CYC = `STC_LOCK_S * 1000 * `STC_CLK_KHZ
) (
  input wire clk,
  input wire rst_b,
  input wire ce,
  input wire nv_fresh,
  input wire rx_valid,
  input wire [7:0] rx_char,
  input wire test_start,
  input wire [2:0] test_kind,
  input wire test_hold,
  input wire store_req,
  input wire [2:0] store_slot,
  input wire restore_req,
  input wire restore_has_slot,
  input wire [2:0] restore_slot,
  input wire restore_factory,
  input wire pw_cmd,
  input wire dist_wr,
  input wire [2:0] dist_idx,
  input wire [23:0] dist_val,
  input wire lbc_on_wr,
  input wire lbc_on_val,
  input wire [2:0] dist_rd_idx,
  input wire log_rd_req,
  input wire [6:0] log_rd_idx,
  input wire err_valid,
  input wire [7:0] err_code,
  input wire [31:0] rtc_now,
  input wire meas_valid,
  input wire [31:0] meas_value,
  input wire barrier_trig,
  input wire [2:0] barrier_sel,
  output wire test_active,
  output reg [2:0] test_kind_out,
  output reg refresh_pulse,
  output reg test_end,
  output reg ser_valid,
  output reg [31:0] ser_value,
  output reg echo_valid,
  output wire [7:0] echo_char,
  output reg illegal_use,
  output wire locked,
  output reg store_done,
  output reg cmd_refused,
  output reg cmd_ignored,
  output reg restore_done,
  output reg prot_on,
  output reg lbc_on,
  output reg [2:0] active_bar,
  output reg [23:0] dist_rd_data,
  output wire [39:0] log_rd_data,
  output wire log_rd_valid,
  output wire [6:0] log_count
);
  // ----------------------------------------
  // States and derived counts
  // ----------------------------------------
  localparam [2:0] ST_BOOT = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_TEST = 3'h2;
  localparam [2:0] ST_PWCHK = 3'h3;
  localparam [2:0] ST_PWNEW = 3'h4;
  localparam [2:0] ST_LOCK = 3'h5;
  localparam [30:0] REF_LAST = REFRESH_CYC[30:0] - 31'h00000001;
  localparam [30:0] SES_LAST = SESSION_CYC[30:0] - 31'h00000001;
  localparam [30:0] LOCK_LAST = LOCK_CYC[30:0] - 31'h00000001;

  reg [2:0] st_reg;
  reg [30:0] cnt_reg;
  reg [30:0] ref_reg;
  reg hold_reg;
  reg auth_reg;
  reg pend_new_reg;
  reg [2:0] pend_slot_reg;
  reg [1:0] fail_reg;
  reg [3:0] buf_len_reg;
  reg [7:0] buf_mem [0:7];
  // Persistent storage: not touched by rst_b, except trig_prev_reg
  reg [7:0] pw_mem [0:7];
  reg [3:0] pw_len_reg;
  reg [23:0] slot_mem [0:39];
  reg slot_on_mem [0:4];
  reg [2:0] nv_last_reg;
  reg trig_prev_reg;
  integer j;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire idle = (st_reg == ST_IDLE);
  wire entry = (st_reg == ST_PWCHK) || (st_reg == ST_PWNEW);
  wire is_esc = rx_valid && (rx_char == `STC_CH_ESC);
  wire is_cr = rx_valid && (rx_char == `STC_CH_CR);
  wire is_dat = rx_valid && !is_esc && !is_cr;
  wire [7:0] up_char = (rx_char >= 8'h61 && rx_char <= 8'h7A) ? rx_char - 8'h20 : rx_char;
  wire any_cmd = test_start | store_req | restore_req | pw_cmd | dist_wr | lbc_on_wr | log_rd_req;
  wire may_store = !prot_on || auth_reg;
  wire pw_match;
  wire [7:0] eq_bits;
  wire [191:0] wd_flat;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_cmp
      localparam [3:0] IX = i;
      // Bytes beyond the stored length do not take part
      assign eq_bits[i] = (IX >= pw_len_reg) || (buf_mem[i] == pw_mem[i]);
    end
  endgenerate
  assign pw_match = (buf_len_reg == pw_len_reg) && (&eq_bits);

  wire store_go = (idle && store_req && store_slot <= `STC_SLOT_MAX && may_store) ||
                  ((st_reg == ST_PWCHK) && is_cr && pw_match && !pend_new_reg);
  wire [2:0] store_at = idle ? store_slot : pend_slot_reg;
  wire [2:0] rs_slot = restore_has_slot ? restore_slot : 3'h0;
  wire restore_go = idle && restore_req && (restore_factory || rs_slot <= `STC_SLOT_MAX);
  wire boot_go = (st_reg == ST_BOOT);
  wire load_w = restore_go || boot_go;
  wire load_fact = (restore_go && restore_factory) || (boot_go && nv_fresh);
  wire [2:0] load_slot = boot_go ? nv_last_reg : rs_slot;
  wire pw_set = (st_reg == ST_PWNEW) && is_cr;

  assign test_active = (st_reg == ST_TEST);
  assign locked = (st_reg == ST_LOCK);
  assign echo_char = `STC_CH_STAR;

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= ST_BOOT;
      cnt_reg <= 31'h00000000;
      ref_reg <= 31'h00000000;
      hold_reg <= 1'b0;
      auth_reg <= 1'b0;
      pend_new_reg <= 1'b0;
      pend_slot_reg <= 3'h0;
      fail_reg <= 2'h0;
      buf_len_reg <= 4'h0;
      test_kind_out <= 3'h0;
      refresh_pulse <= 1'b0;
      test_end <= 1'b0;
      echo_valid <= 1'b0;
      illegal_use <= 1'b0;
      store_done <= 1'b0;
      cmd_refused <= 1'b0;
      cmd_ignored <= 1'b0;
      restore_done <= 1'b0;
    end else if (ce) begin
      refresh_pulse <= 1'b0;
      test_end <= 1'b0;
      echo_valid <= 1'b0;
      illegal_use <= 1'b0;
      store_done <= store_go;
      restore_done <= restore_go;
      cmd_refused <= 1'b0;
      cmd_ignored <= any_cmd && !idle;
      case (st_reg)
        ST_BOOT: begin
          st_reg <= ST_IDLE;
        end
        ST_IDLE: begin
          if (test_start) begin
            st_reg <= ST_TEST;
            cnt_reg <= 31'h00000000;
            ref_reg <= 31'h00000000;
            hold_reg <= test_hold;
            test_kind_out <= test_kind;
          end else if (store_req) begin
            if (store_slot > `STC_SLOT_MAX) begin
              cmd_refused <= 1'b1;
            end else if (!may_store) begin
              st_reg <= ST_PWCHK;
              pend_new_reg <= 1'b0;
              pend_slot_reg <= store_slot;
              buf_len_reg <= 4'h0;
            end
          end else if (restore_req && !restore_go) begin
            cmd_refused <= 1'b1;
          end else if (pw_cmd) begin
            st_reg <= may_store ? ST_PWNEW : ST_PWCHK;
            pend_new_reg <= 1'b1;
            buf_len_reg <= 4'h0;
          end else if (dist_wr && dist_val > `STC_DIST_MAX) begin
            cmd_refused <= 1'b1;
          end
        end
        ST_TEST: begin
          if (ref_reg == REF_LAST) begin
            ref_reg <= 31'h00000000;
            refresh_pulse <= !is_esc && (hold_reg || cnt_reg != SES_LAST);
          end else begin
            ref_reg <= ref_reg + 31'h00000001;
          end
          cnt_reg <= cnt_reg + 31'h00000001;
          if (is_esc) begin
            st_reg <= ST_IDLE;
            test_end <= 1'b1;
          end else if (!hold_reg && cnt_reg == SES_LAST) begin
            st_reg <= ST_IDLE;
            test_end <= 1'b1;
          end
        end
        ST_PWCHK, ST_PWNEW: begin
          if (is_esc) begin
            st_reg <= ST_IDLE;
          end else if (is_dat && buf_len_reg < `STC_PW_MAX) begin
            buf_len_reg <= buf_len_reg + 4'h1;
            echo_valid <= 1'b1;
          end else if (is_cr && st_reg == ST_PWNEW) begin
            st_reg <= ST_IDLE;
          end else if (is_cr && pw_match) begin
            auth_reg <= 1'b1;
            fail_reg <= 2'h0;
            buf_len_reg <= 4'h0;
            st_reg <= pend_new_reg ? ST_PWNEW : ST_IDLE;
          end else if (is_cr) begin
            cmd_refused <= 1'b1;
            cnt_reg <= 31'h00000000;
            if (fail_reg == `STC_FAIL_LIMIT) begin
              illegal_use <= 1'b1;
              st_reg <= ST_LOCK;
            end else begin
              fail_reg <= fail_reg + 2'h1;
              st_reg <= ST_IDLE;
            end
          end
        end
        ST_LOCK: begin
          cnt_reg <= cnt_reg + 31'h00000001;
          if (cnt_reg == LOCK_LAST) begin
            st_reg <= ST_IDLE;
            fail_reg <= 2'h0;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Password and slot storage
  // ----------------------------------------
  always @(posedge clk) begin
    if (ce) begin
      if (entry && is_dat && buf_len_reg < `STC_PW_MAX) begin
        buf_mem[buf_len_reg[2:0]] <= up_char;
      end
      if (boot_go && nv_fresh) begin
        // Blank store: preset password and factory slots
        pw_mem[0] <= `STC_PW_DEF0;
        pw_mem[1] <= `STC_PW_DEF1;
        pw_mem[2] <= `STC_PW_DEF2;
        pw_mem[3] <= `STC_PW_DEF3;
        pw_len_reg <= `STC_PW_DEF_LEN;
        prot_on <= 1'b1;
        nv_last_reg <= 3'h0;
        for (j = 0; j < 40; j = j + 1) begin
          slot_mem[j] <= `STC_FACT_DIST;
        end
        for (j = 0; j < 5; j = j + 1) begin
          slot_on_mem[j] <= `STC_FACT_LBC_ON;
        end
      end
      if (pw_set) begin
        for (j = 0; j < 8; j = j + 1) begin
          pw_mem[j] <= buf_mem[j];
        end
        pw_len_reg <= buf_len_reg;
        prot_on <= (buf_len_reg != 4'h0);
      end
      if (store_go) begin
        for (j = 0; j < 8; j = j + 1) begin
          slot_mem[{store_at, j[2:0]}] <= wd_flat[j*24 +: 24];
        end
        slot_on_mem[store_at] <= lbc_on;
        nv_last_reg <= store_at;
      end
      if (restore_go && !restore_factory) begin
        nv_last_reg <= rs_slot;
      end
    end
  end

  // ----------------------------------------
  // Working parameters
  // ----------------------------------------
  generate
    for (i = 0; i < `STC_NUM_BAR; i = i + 1) begin : g_dist
      localparam [2:0] IX = i;
      reg [23:0] wd_reg;
      always @(posedge clk) begin
        if (!rst_b) begin
          wd_reg <= `STC_FACT_DIST;
        end else if (ce) begin
          if (load_w) begin
            // Unsaved edits are overwritten here
            wd_reg <= load_fact ? `STC_FACT_DIST : slot_mem[{load_slot, IX}];
          end else if (idle && dist_wr && dist_idx == IX && dist_val <= `STC_DIST_MAX) begin
            wd_reg <= dist_val;
          end
        end
      end
      assign wd_flat[i*24 +: 24] = wd_reg;
    end
  endgenerate

  always @(posedge clk) begin
    if (!rst_b) begin
      lbc_on <= `STC_FACT_LBC_ON;
      dist_rd_data <= 24'h000000;
    end else if (ce) begin
      dist_rd_data <= wd_flat[dist_rd_idx*24 +: 24];
      if (load_w) begin
        lbc_on <= load_fact ? `STC_FACT_LBC_ON : slot_on_mem[load_slot];
      end else if (idle && lbc_on_wr) begin
        lbc_on <= lbc_on_val;
      end
    end
  end

  // ----------------------------------------
  // Barrier offset and serial value
  // ----------------------------------------
  wire [3:0] bar_sync;
  stc_sync3 #(
    .W(4)
  ) u_bar_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .d_in({barrier_trig, barrier_sel}),
    .q_out(bar_sync)
  );

  wire [23:0] offs = lbc_on ? wd_flat[active_bar*24 +: 24] : 24'h000000;

  always @(posedge clk) begin
    if (!rst_b) begin
      trig_prev_reg <= 1'b0;
      active_bar <= 3'h0;
      ser_valid <= 1'b0;
      ser_value <= 32'h00000000;
    end else if (ce) begin
      trig_prev_reg <= bar_sync[3];
      if (bar_sync[3] && !trig_prev_reg) begin
        active_bar <= bar_sync[2:0];
      end
      // Held off while a test owns the line
      ser_valid <= meas_valid && !test_active;
      if (meas_valid && !test_active) begin
        ser_value <= meas_value + {8'h00, offs};
      end
    end
  end

  // ----------------------------------------
  // Error log
  // ----------------------------------------
  stc_err_log u_log (
    .clk(clk),
    .ce(ce),
    .init(boot_go && nv_fresh),
    .wr_en(err_valid),
    .wr_data({rtc_now, err_code}),
    .rd_en(idle && log_rd_req),
    .rd_idx(log_rd_idx),
    .rd_data(log_rd_data),
    .rd_valid(log_rd_valid),
    .count(log_count)
  );
endmodule

// ==== tb/stc_unit_assertions.sv ====
// Assertion checker for the service and test command unit
`timescale 1ns/10ps
module stc_unit_assertions #(
  parameter integer REFRESH_CYC = 20,
  parameter integer SESSION_CYC = 200,
  parameter integer LOCK_CYC = 100
) (
  input wire clk,
  input wire rst_b,
  input wire ce,
  input wire rx_valid,
  input wire [7:0] rx_char,
  input wire test_start,
  input wire test_hold,
  input wire meas_valid,
  input wire [31:0] meas_value,
  input wire err_valid,
  input wire test_active,
  input wire refresh_pulse,
  input wire test_end,
  input wire ser_valid,
  input wire [31:0] ser_value,
  input wire echo_valid,
  input wire [7:0] echo_char,
  input wire illegal_use,
  input wire locked,
  input wire cmd_ignored,
  input wire lbc_on,
  input wire [6:0] log_count
);
  // ------
  // Helper counters
  // ------
  reg [31:0] ref_cnt_reg;
  reg [31:0] act_cnt_reg;
  reg [31:0] lock_cnt_reg;
  reg hold_reg;
  wire esc_in = ce && rx_valid && rx_char == 8'h1B;
  // Hold option latched while idle, so the launch value sticks
  always @(posedge clk) begin
    ref_cnt_reg <= (!test_active || refresh_pulse) ? 32'h0 : ref_cnt_reg + 32'h1;
    act_cnt_reg <= test_active ? act_cnt_reg + 32'h1 : 32'h0;
    lock_cnt_reg <= locked ? lock_cnt_reg + 32'h1 : 32'h0;
    if (!test_active) begin
      hold_reg <= test_hold;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ------
  // Properties
  // ------
  sequence s_stop;
    test_end ##[0:1] !test_active;
  endsequence
  property p_refresh;
    refresh_pulse |-> test_active && ref_cnt_reg + 32'h1 >= REFRESH_CYC && ref_cnt_reg <= REFRESH_CYC + 1;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh spacing wrong");
  property p_timeout;
    test_active && !hold_reg |-> act_cnt_reg <= SESSION_CYC + 2;
  endproperty
  a_timeout: assert property (p_timeout) else $error("session overran");
  property p_esc;
    test_active && esc_in |=> s_stop;
  endproperty
  a_esc: assert property (p_esc) else $error("escape did not stop session");
  property p_hold;
    test_active && hold_reg && act_cnt_reg > 32'h1 && !esc_in |=> !test_end;
  endproperty
  a_hold: assert property (p_hold) else $error("held session ended");
  property p_quiet;
    ce && meas_valid && test_active |=> !ser_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output during session");
  property p_log;
    ce && err_valid && log_count < 7'd124 |=> log_count == $past(log_count) + 7'h01;
  endproperty
  a_log: assert property (p_log) else $error("log count not advanced");
  property p_log_max;
    log_count <= 7'd124;
  endproperty
  a_log_max: assert property (p_log_max) else $error("log count too big");
  property p_star;
    echo_valid |-> $past(rx_valid) && echo_char == 8'h2A;
  endproperty
  a_star: assert property (p_star) else $error("bad echo");
  property p_lock;
    illegal_use |-> ##[0:1] locked;
  endproperty
  a_lock: assert property (p_lock) else $error("no lock after illegal use");
  property p_lock_len;
    locked |-> lock_cnt_reg <= LOCK_CYC + 2 && !(ce && test_start) or ##1 cmd_ignored;
  endproperty
  a_lock_len: assert property (p_lock_len) else $error("lock too long or command taken");
  property p_plain;
    ce && meas_valid && !test_active && !lbc_on |=> ser_valid && ser_value == $past(meas_value);
  endproperty
  a_plain: assert property (p_plain) else $error("plain output wrong");
endmodule
bind stc_unit stc_unit_assertions #(
  .REFRESH_CYC(REFRESH_CYC),
  .SESSION_CYC(SESSION_CYC),
  .LOCK_CYC(LOCK_CYC)
) stc_unit_assertions_i (.*);

// ==== tb/stc_host_model.sv ====
// Host terminal model sending characters to the unit
`timescale 1ns/10ps
module stc_host_model (
  input wire clk,
  output reg rx_valid,
  output reg [7:0] rx_char
);
  initial begin
    rx_valid = 1'h0;
    rx_char = 8'h00;
  end
  // Gap sets a prompt or slow host
  task send(input [7:0] c, input integer gap);
    begin
      @(posedge clk);
      rx_valid <= 1'h1;
      rx_char <= c;
      @(posedge clk);
      rx_valid <= 1'h0;
      rx_char <= ~c;
      repeat (gap) @(posedge clk);
    end
  endtask
  task esc;
    send(8'h1B, 3);
  endtask
  task line(input [63:0] s, input integer n);
    integer k;
    begin
      for (k = n - 1; k >= 0; k = k - 1) begin
        send(s[8*k+:8], 1);
      end
      send(8'h0D, 0);
    end
  endtask
endmodule

// ==== tb/stc_unit_test.sv ====
// Self-checking testbench for the service and test command unit
`timescale 1ns/10ps
`include "stc_map.vh"
module stc_unit_test;
  // ------
  // Signals and instances
  // ------
  reg clk = 1'h0, rst_b = 1'h0, ce = 1'h1, nv_fresh = 1'h1, test_start = 1'h0, test_hold = 1'h0;
  reg store_req = 1'h0, restore_req = 1'h0, restore_has_slot = 1'h0, restore_factory = 1'h0, pw_cmd = 1'h0;
  reg dist_wr = 1'h0, lbc_on_wr = 1'h0, lbc_on_val = 1'h0, log_rd_req = 1'h0, err_valid = 1'h0;
  reg meas_valid = 1'h0, barrier_trig = 1'h0;
  reg [2:0] test_kind = 3'h0, store_slot = 3'h0, restore_slot = 3'h0, dist_idx = 3'h0, dist_rd_idx = 3'h0;
  reg [2:0] barrier_sel = 3'h0;
  reg [23:0] dist_val = 24'h0;
  reg [6:0] log_rd_idx = 7'h0;
  reg [7:0] err_code = 8'h0;
  reg [31:0] rtc_now = 32'h0, meas_value = 32'h0;
  wire test_active, refresh_pulse, test_end, ser_valid, echo_valid, illegal_use, locked, store_done;
  wire cmd_refused, cmd_ignored, restore_done, prot_on, lbc_on, log_rd_valid, rx_valid;
  wire [2:0] test_kind_out, active_bar;
  wire [7:0] echo_char, rx_char;
  wire [23:0] dist_rd_data;
  wire [31:0] ser_value;
  wire [39:0] log_rd_data;
  wire [6:0] log_count;
  wire [8:0] pl = {log_rd_valid, ser_valid, test_end, illegal_use, store_done, cmd_refused, cmd_ignored, restore_done,
    refresh_pulse};
  reg [8:0] seen = 9'h000;
  reg [95:0] rows [0:3];
  reg [95:0] r;
  integer errors = 0, checked = 0, nref = 0, necho = 0, i, e;
  always #20 clk = ~clk;
  // Pulses are gathered here so no check hangs on one exact edge
  always @(posedge clk) begin
    seen <= seen | pl;
    nref <= nref + pl[0];
    necho <= necho + (echo_valid && echo_char === `STC_CH_STAR);
  end
  stc_unit #(.REFRESH_CYC(20), .SESSION_CYC(200), .LOCK_CYC(100)) stc_unit_i (.*);
  stc_host_model stc_host_model_i (.clk(clk), .rx_valid(rx_valid), .rx_char(rx_char));
  // ------
  // Tasks
  // ------
  task chk(input [8*10-1:0] nm, input [39:0] got, input [39:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("unexpected %0s: expected %h, seen %h", nm, exp, got);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task clr;
    begin
      #1;
      seen = 9'h000;
      nref = 0;
      necho = 0;
    end
  endtask
  // 0 store, 1 restore, 2 password, 3 distance, 4 offset, 5 log, 6 test, 7 measure
  task cmd(input [2:0] c);
    begin
      @(posedge clk);
      {meas_valid, test_start, log_rd_req, lbc_on_wr, dist_wr, pw_cmd, restore_req, store_req} <= 8'h01 << c;
      @(posedge clk);
      {meas_valid, test_start, log_rd_req, lbc_on_wr, dist_wr, pw_cmd, restore_req, store_req} <= 8'h00;
    end
  endtask
  task rst;
    begin
      rst_b <= 1'h0;
      wt(2);
      rst_b <= 1'h1;
      wt(3);
    end
  endtask
  initial begin
    #200000;
    errors = errors + 1;
    end_of_test;
  end
  // ------
  // Main sequence
  // ------
  initial begin
    rows[0] = {8'h00, 24'h000001, 32'h00000010, 32'h00000011};
    rows[1] = {8'h07, 24'h98967F, 32'h00000001, 32'h00989680};
    rows[2] = {8'h03, 24'h000000, 32'hFFFFFFFF, 32'hFFFFFFFF};
    rows[3] = {8'h05, 24'h123456, 32'h00000000, 32'h00123456};
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    wt(3);
    chk("reset", {prot_on, lbc_on, test_active, locked, log_count}, 40'h400);
    meas_value <= 32'h00001234;
    cmd(7);
    wt(3);
    chk("plain", ser_value, 32'h00001234);
    ce <= 1'h0;
    meas_value <= 32'h00000077;
    cmd(7);
    wt(3);
    chk("frozen", {ser_value, ser_valid}, 33'h000002468);
    ce <= 1'h1;
    dist_val <= `STC_DIST_MAX + 24'h000001;
    clr;
    cmd(3);
    wt(3);
    chk("too far", seen[3], 1'h1);
    lbc_on_val <= 1'h1;
    cmd(4);
    for (i = 0; i < 4; i = i + 1) begin
      r = rows[i];
      dist_idx <= r[90:88];
      dist_val <= r[87:64];
      barrier_sel <= r[90:88];
      dist_rd_idx <= r[90:88];
      meas_value <= r[63:32];
      cmd(3);
      barrier_trig <= 1'h1;
      wt(4);
      barrier_trig <= 1'h0;
      wt(6);
      cmd(7);
      wt(3);
      chk("barrier", active_bar, r[90:88]);
      chk("distance", dist_rd_data, r[87:64]);
      chk("offset", ser_value, r[31:0]);
    end
    $display("test offset rows done");
    for (i = 0; i < 5; i = i + 1) begin
      test_kind <= i[2:0];
      clr;
      cmd(6);
      wt(2);
      chk("kind", test_kind_out, i[2:0]);
      cmd(7);
      stc_host_model_i.esc;
      chk("abort", {seen[7:6], test_active}, 3'h2);
    end
    clr;
    cmd(6);
    wt(149);
    chk("refresh", {nref[7:0], test_active}, 9'h00F);
    wt(60);
    chk("timeout", {seen[6], test_active}, 2'h2);
    test_hold <= 1'h1;
    cmd(6);
    test_hold <= 1'h0;
    wt(260);
    chk("held", test_active, 1'h1);
    stc_host_model_i.esc;
    $display("test sessions done");
    for (i = 0; i < 3; i = i + 1) begin
      clr;
      cmd(0);
      stc_host_model_i.line("xyz", 3);
      wt(3);
      chk("bad pw", {seen[5:3], locked}, i == 2 ? 4'hB : 4'h2);
    end
    clr;
    cmd(6);
    wt(3);
    chk("ignored", {seen[2], test_active}, 2'h2);
    wt(100);
    clr;
    cmd(0);
    stc_host_model_i.line("xyz", 3);
    wt(3);
    chk("recount", {seen[5:3], locked}, 4'h2);
    store_slot <= 3'h2;
    clr;
    cmd(0);
    stc_host_model_i.line("wega", 4);
    wt(3);
    chk("store", {seen[4], necho[3:0]}, 5'h14);
    $display("test password done");
    dist_idx <= 3'h0;
    dist_val <= 24'h000055;
    dist_rd_idx <= 3'h0;
    cmd(3);
    restore_has_slot <= 1'h1;
    restore_slot <= 3'h2;
    clr;
    cmd(1);
    wt(3);
    chk("restore", dist_rd_data, 24'h000001);
    chk("restored", seen[1], 1'h1);
    restore_slot <= 3'h5;
    clr;
    cmd(1);
    wt(3);
    chk("bad slot", seen[3], 1'h1);
    restore_has_slot <= 1'h0;
    cmd(1);
    wt(3);
    chk("slot 0", dist_rd_data, 24'h000000);
    restore_has_slot <= 1'h1;
    restore_slot <= 3'h2;
    cmd(1);
    restore_factory <= 1'h1;
    cmd(1);
    restore_factory <= 1'h0;
    wt(3);
    chk("factory", {dist_rd_data, lbc_on}, 25'h0);
    nv_fresh <= 1'h0;
    rst;
    chk("boot slot", {dist_rd_data, lbc_on}, 25'h3);
    $display("test restore done");
    cmd(2);
    stc_host_model_i.line("WeGa", 4);
    stc_host_model_i.esc;
    chk("pw kept", prot_on, 1'h1);
    cmd(2);
    stc_host_model_i.line("", 0);
    wt(3);
    chk("pw off", prot_on, 1'h0);
    rst;
    clr;
    cmd(0);
    wt(3);
    chk("free store", {seen[4], prot_on}, 2'h2);
    for (i = 0; i < 126; i = i + 1) begin
      @(posedge clk);
      err_valid <= 1'h1;
      err_code <= i[7:0];
      rtc_now <= i;
    end
    @(posedge clk);
    err_valid <= 1'h0;
    wt(2);
    chk("log count", log_count, 7'd124);
    for (i = 0; i < 2; i = i + 1) begin
      e = i * 123 + 2;
      log_rd_idx <= i * 123;
      clr;
      cmd(5);
      wt(2);
      chk("log entry", log_rd_data, {e[31:0], e[7:0]});
      chk("log valid", seen[8], 1'h1);
    end
    $display("test error log done");
    end_of_test;
  end
endmodule
